/* File: core/rci_cause_dec.sv */
// Fixed-priority decoder of the reset and wake-up cause.
`timescale 1ns/1ps
`default_nettype none
module rci_cause_dec (
  input  wire logic              por_req,
  input  wire logic              bor_req,
  input  wire logic              ext_evt,
  input  wire logic              wdt_timeout,
  input  wire logic              irq_wake,
  input  wire logic              sleeping,
  output var rci_pkg::rci_cause_t cause
);
  import rci_pkg::*;

  always_comb begin
    cause = CAUSE_NONE;
    if (por_req) begin
      cause = CAUSE_POR;
    end else if (bor_req) begin
      cause = CAUSE_BOR;
    end else if (ext_evt) begin
      cause = sleeping ? CAUSE_EXT_SLEEP : CAUSE_EXT_RUN;
    end else if (wdt_timeout) begin
      cause = sleeping ? CAUSE_WDT_WAKE : CAUSE_WDT_RST;
    end else if (irq_wake && sleeping) begin
      cause = CAUSE_IRQ_WAKE;
    end
  end
endmodule : rci_cause_dec
`default_nettype wire

/* File: core/rci_consts.svh */
// Constants for the reset-cause initialization logic.
// Overview of operation
// - Run pin reset: PC zero, clear status top.
// - Sleep pin reset: PC zero, TO set, PD clear.
// - Interrupt wake: PC+1, TO set, PD clear.
// - Interrupt wake with enable set: next instruction, then vector.
// - Only power-on and brown-out clear power flag bit 0.
// - Interrupt wake sets its source flag bits.
// - Mask shares address; reachable only in mode 1001.
// - Unimplemented bits always read as zero.
// - Every reset clears the global interrupt enable.
`ifndef RCI_CONSTS_SVH
`define RCI_CONSTS_SVH

`define RCI_IDX_PC      8'h02
`define RCI_IDX_STATUS  8'h03
`define RCI_IDX_IRQCTL  8'h0B
`define RCI_IDX_PFLAG   8'h0C
`define RCI_IDX_SMODE   8'h14
`define RCI_IDX_POWER_CONTROL_FLAGS    8'h8E
`define RCI_IDX_SADDR   8'h93
`define RCI_IDX_EVSTAT  8'hC0
`define RCI_IDX_EVMASK  8'hC1

`define RCI_ST_TO       4
`define RCI_ST_PD       3
`define RCI_PCN_BOR     0
`define RCI_PCN_ULPWUE  5
`define RCI_GIE         7

`define RCI_POWER_CONTROL_FLAGS_IMPL   8'h33
`define RCI_PFLAG_IMPL  8'h7F
`define RCI_EV_IMPL     8'h7F
`define RCI_STATUS_POR  8'h18
`define RCI_POWER_CONTROL_FLAGS_POR    8'h10
`define RCI_IRQCTL_POR  8'h00
`define RCI_SADDR_POR   8'h00
`define RCI_SADDR_RST   8'hFF
`define RCI_SMASK_RST   8'hFF
`define RCI_SMODE_MASK  4'h9
`define RCI_PC_ZERO     13'h0000
`define RCI_PC_VECTOR   13'h0004
`define RCI_EV_POR_RST  8'h01

`endif

/* File: core/rci_pkg.sv */
// Types shared by the reset-cause initialization logic.
package rci_pkg;
  typedef enum logic [2:0] {
    CAUSE_NONE, CAUSE_POR, CAUSE_BOR, CAUSE_EXT_RUN, CAUSE_EXT_SLEEP,
    CAUSE_WDT_RST, CAUSE_WDT_WAKE, CAUSE_IRQ_WAKE
  } rci_cause_t;
  typedef enum logic {VEC_IDLE, VEC_WAIT} rci_vec_t;
endpackage : rci_pkg

/* File: core/rci_top.sv */
// Reset-cause initialization logic with its AHB-Lite register slave.
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rci_consts.svh"
module rci_top #(
  parameter int PC_W = 13
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              external_reset_pin_n,
  input  wire logic              por_req,
  input  wire logic              bor_req,
  input  wire logic              wdt_timeout,
  input  wire logic              sleeping,
  input  wire logic              instr_done,
  input  wire logic [PC_W-1:0]   core_pc,
  input  wire logic [2:0]        wake_ctl_flags,
  input  wire logic [6:0]        wake_per_flags,
  output logic                   pc_load,
  output logic      [PC_W-1:0]   pc_value,
  output logic                   global_irq_enable,
  output logic                   irq
);
  import rci_pkg::*;

  logic              ext_s1_ff, ext_s2_ff, ext_s3_ff, ext_lvl_ff;
  logic              ext_evt;
  rci_cause_t        cause;
  logic              is_reset;
  logic [7:0]        status_ff, power_control_flags_ff, irqctl_ff, pflag_ff;
  logic [7:0]        saddr_ff, smask_ff, evstat_ff, evmask_ff;
  logic [3:0]        smode_ff;
  logic              wr_pend_ff;
  logic [7:0]        wr_idx_ff;
  logic [31:0]       hrdata_ff;
  logic              pc_load_ff, irq_ff;
  logic [PC_W-1:0]   pc_value_ff;
  rci_vec_t          vec_ff;
  logic              accept, addr_ok, rd_clr, vec_fire;
  logic [7:0]        idx;
  logic [31:0]       nxt_hrdata;
  logic [7:0]        ev_set, nxt_evstat;

  function automatic logic [7:0] status_init(rci_cause_t c, logic [7:0] s);
    case (c)
      CAUSE_POR:       status_init = `RCI_STATUS_POR;
      CAUSE_BOR:       status_init = {3'h0, 2'b11, s[2:0]};
      CAUSE_EXT_RUN:   status_init = {3'h0, s[4:0]};
      CAUSE_EXT_SLEEP: status_init = {3'h0, 2'b10, s[2:0]};
      CAUSE_WDT_RST:   status_init = {4'h0, s[3:0]};
      CAUSE_WDT_WAKE:  status_init = {s[7:5], 2'b00, s[2:0]};
      CAUSE_IRQ_WAKE:  status_init = {s[7:5], 2'b10, s[2:0]};
      default:         status_init = s;
    endcase
  endfunction : status_init

  function automatic logic [7:0] power_control_flags_init(rci_cause_t c, logic [7:0] p);
    case (c)
      CAUSE_POR:     power_control_flags_init = `RCI_POWER_CONTROL_FLAGS_POR;
      CAUSE_BOR:     power_control_flags_init = (p & 8'h02) | 8'h10;
      CAUSE_EXT_RUN, CAUSE_EXT_SLEEP, CAUSE_WDT_RST: begin
        power_control_flags_init = p & 8'h13;
      end
      default:       power_control_flags_init = p;
    endcase
  endfunction : power_control_flags_init

  // The pin is a foreign level: three stages, counted once stages two and three agree.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1_ff  <= 1'b1;
      ext_s2_ff  <= 1'b1;
      ext_s3_ff  <= 1'b1;
      ext_lvl_ff <= 1'b1;
    end else begin
      ext_s1_ff <= external_reset_pin_n;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
      if (ext_s2_ff == ext_s3_ff) begin
        ext_lvl_ff <= ext_s3_ff;
      end
    end
  end

  assign ext_evt = (ext_s2_ff == ext_s3_ff) && !ext_s3_ff && ext_lvl_ff;

  rci_cause_dec rci_cause_dec_i (
    .por_req     (por_req),
    .bor_req     (bor_req),
    .ext_evt     (ext_evt),
    .wdt_timeout (wdt_timeout),
    .irq_wake    ((|wake_ctl_flags) || (|wake_per_flags)),
    .sleeping    (sleeping),
    .cause       (cause)
  );

  assign is_reset = (cause == CAUSE_POR) || (cause == CAUSE_BOR) ||
                    (cause == CAUSE_EXT_RUN) || (cause == CAUSE_EXT_SLEEP) ||
                    (cause == CAUSE_WDT_RST);

  // Bus address phase: only whole-word transfers inside the map are honoured.
  assign idx     = haddr[9:2];
  assign addr_ok = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'b00);
  assign accept  = hsel && htrans[1] && hready && addr_ok && (hsize == 3'b010);
  assign rd_clr  = accept && !hwrite && (idx == `RCI_IDX_EVSTAT);

  always_comb begin
    nxt_hrdata = 32'h0;
    case (idx)
      `RCI_IDX_PC:     nxt_hrdata = {{(32-PC_W){1'b0}}, pc_value_ff};
      `RCI_IDX_STATUS: nxt_hrdata = {24'h0, status_ff};
      `RCI_IDX_IRQCTL: nxt_hrdata = {24'h0, irqctl_ff};
      `RCI_IDX_PFLAG:  nxt_hrdata = {24'h0, pflag_ff & `RCI_PFLAG_IMPL};
      `RCI_IDX_SMODE:  nxt_hrdata = {28'h0, smode_ff};
      `RCI_IDX_POWER_CONTROL_FLAGS:   nxt_hrdata = {24'h0, power_control_flags_ff & `RCI_POWER_CONTROL_FLAGS_IMPL};
      `RCI_IDX_SADDR: begin
        nxt_hrdata = {24'h0, (smode_ff == `RCI_SMODE_MASK) ? smask_ff : saddr_ff};
      end
      `RCI_IDX_EVSTAT: nxt_hrdata = {24'h0, evstat_ff};
      `RCI_IDX_EVMASK: nxt_hrdata = {24'h0, evmask_ff};
      default:         nxt_hrdata = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff  <= 32'h0;
      wr_pend_ff <= 1'b0;
      wr_idx_ff  <= 8'h00;
    end else begin
      hrdata_ff  <= (accept && !hwrite) ? nxt_hrdata : 32'h0;
      wr_pend_ff <= accept && hwrite;
      wr_idx_ff  <= idx;
    end
  end

  // Status: hardware initialization wins over a write landing in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_ff <= `RCI_STATUS_POR;
    end else if (cause != CAUSE_NONE) begin
      status_ff <= status_init(cause, status_ff);
    end else if (wr_pend_ff && wr_idx_ff == `RCI_IDX_STATUS) begin
      status_ff <= {hwdata[7:5], status_ff[4:3], hwdata[2:0]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_control_flags_ff <= `RCI_POWER_CONTROL_FLAGS_POR;
    end else if (cause != CAUSE_NONE) begin
      power_control_flags_ff <= power_control_flags_init(cause, power_control_flags_ff);
    end else if (wr_pend_ff && wr_idx_ff == `RCI_IDX_POWER_CONTROL_FLAGS) begin
      power_control_flags_ff <= hwdata[7:0] & `RCI_POWER_CONTROL_FLAGS_IMPL;
    end
  end

  assign vec_fire = (vec_ff == VEC_WAIT) && instr_done && !is_reset;

  // Wake sources land in the flag registers except in a reset cycle; a set beats a software clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irqctl_ff <= `RCI_IRQCTL_POR;
    end else if (cause == CAUSE_POR || cause == CAUSE_BOR) begin
      irqctl_ff <= `RCI_IRQCTL_POR;
    end else if (is_reset) begin
      irqctl_ff <= {7'h0, irqctl_ff[0]};
    end else begin
      if (wr_pend_ff && wr_idx_ff == `RCI_IDX_IRQCTL) begin
        irqctl_ff <= {hwdata[7:3], hwdata[2:0] | wake_ctl_flags};
      end else begin
        irqctl_ff <= {irqctl_ff[7:3], irqctl_ff[2:0] | wake_ctl_flags};
      end
      if (vec_fire) begin
        irqctl_ff[`RCI_GIE] <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pflag_ff <= 8'h00;
    end else if (is_reset) begin
      pflag_ff <= 8'h00;
    end else if (wr_pend_ff && wr_idx_ff == `RCI_IDX_PFLAG) begin
      pflag_ff <= (hwdata[7:0] & `RCI_PFLAG_IMPL) | {1'b0, wake_per_flags};
    end else begin
      pflag_ff <= pflag_ff | {1'b0, wake_per_flags};
    end
  end

  // Serial address and mask share one index; the mode field picks the target.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      smode_ff <= 4'h0;
      saddr_ff <= `RCI_SADDR_POR;
      smask_ff <= `RCI_SMASK_RST;
    end else if (is_reset) begin
      smode_ff <= 4'h0;
      saddr_ff <= (cause == CAUSE_POR) ? `RCI_SADDR_POR : `RCI_SADDR_RST;
      smask_ff <= `RCI_SMASK_RST;
    end else if (wr_pend_ff) begin
      if (wr_idx_ff == `RCI_IDX_SMODE) begin
        smode_ff <= hwdata[3:0];
      end
      if (wr_idx_ff == `RCI_IDX_SADDR && smode_ff == `RCI_SMODE_MASK) begin
        smask_ff <= hwdata[7:0];
      end else if (wr_idx_ff == `RCI_IDX_SADDR) begin
        saddr_ff <= hwdata[7:0];
      end
    end
  end

  // Program counter loads and the deferred jump to the interrupt vector.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_load_ff  <= 1'b0;
      pc_value_ff <= `RCI_PC_ZERO;
      vec_ff      <= VEC_IDLE;
    end else begin
      pc_load_ff <= 1'b0;
      case (vec_ff)
        VEC_IDLE: begin
          if (cause == CAUSE_IRQ_WAKE && irqctl_ff[`RCI_GIE]) begin
            vec_ff <= VEC_WAIT;
          end
        end
        VEC_WAIT: begin
          if (is_reset || vec_fire) begin
            vec_ff <= VEC_IDLE;
          end
        end
        default: vec_ff <= VEC_IDLE;
      endcase
      if (is_reset) begin
        pc_load_ff  <= 1'b1;
        pc_value_ff <= `RCI_PC_ZERO;
      end else if (cause == CAUSE_IRQ_WAKE || cause == CAUSE_WDT_WAKE) begin
        pc_load_ff  <= 1'b1;
        pc_value_ff <= PC_W'(core_pc + 1'b1);
      end else if (vec_fire) begin
        pc_load_ff  <= 1'b1;
        pc_value_ff <= `RCI_PC_VECTOR;
      end
    end
  end

  // Cause events: sticky, cleared by reading; a new event beats that clear.
  always_comb begin
    ev_set = 8'h00;
    if (cause != CAUSE_NONE) begin
      ev_set[3'(cause) - 3'd1] = 1'b1;
    end
    nxt_evstat = ((rd_clr ? 8'h00 : evstat_ff) | ev_set) & `RCI_EV_IMPL;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evstat_ff <= `RCI_EV_POR_RST;
      evmask_ff <= 8'h00;
      irq_ff    <= 1'b0;
    end else begin
      evstat_ff <= nxt_evstat;
      if (wr_pend_ff && wr_idx_ff == `RCI_IDX_EVMASK) begin
        evmask_ff <= hwdata[7:0] & `RCI_EV_IMPL;
      end
      irq_ff <= |(nxt_evstat & evmask_ff);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign hrdata            = hrdata_ff;
  assign pc_load           = pc_load_ff;
  assign pc_value          = pc_value_ff;
  assign global_irq_enable = irqctl_ff[`RCI_GIE];
  assign irq               = irq_ff;

  sequence s_wake_gie;
    (cause == CAUSE_IRQ_WAKE) && irqctl_ff[`RCI_GIE];
  endsequence

  sequence s_vec_jump;
    pc_load && (pc_value == `RCI_PC_VECTOR) && !irqctl_ff[`RCI_GIE];
  endsequence

  property p_ext_run;
    @(posedge hclk) disable iff (!hresetn)
    (cause == CAUSE_EXT_RUN) |=> pc_load && (pc_value == `RCI_PC_ZERO) &&
      (status_ff[7:5] == 3'h0) && (status_ff[4:0] == $past(status_ff[4:0])) &&
      !power_control_flags_ff[`RCI_PCN_ULPWUE] && (power_control_flags_ff[4:0] == $past(power_control_flags_ff[4:0]));
  endproperty
  a_ext_run: assert property (p_ext_run) else $error("pin reset in run misloaded");

  property p_ext_sleep;
    @(posedge hclk) disable iff (!hresetn)
    (cause == CAUSE_EXT_SLEEP) |=> pc_load && (pc_value == `RCI_PC_ZERO) &&
      (status_ff[7:3] == 5'b00010) && (status_ff[2:0] == $past(status_ff[2:0]));
  endproperty
  a_ext_sleep: assert property (p_ext_sleep) else $error("pin reset in sleep misloaded");

  property p_irq_wake;
    @(posedge hclk) disable iff (!hresetn)
    (cause == CAUSE_IRQ_WAKE) |=> pc_load && (pc_value == PC_W'($past(core_pc) + 1'b1)) &&
      status_ff[`RCI_ST_TO] && !status_ff[`RCI_ST_PD] && $stable(power_control_flags_ff);
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("interrupt wake misloaded");

  property p_vector;
    @(posedge hclk) disable iff (!hresetn)
    s_wake_gie ##[1:100] (instr_done && (cause == CAUSE_NONE) && (vec_ff == VEC_WAIT)) |=>
      s_vec_jump;
  endproperty
  a_vector: assert property (p_vector) else $error("no vector after wake");

  property p_bor_bit;
    @(posedge hclk) disable iff (!hresetn)
    (cause != CAUSE_NONE && cause != CAUSE_POR) |=>
      (power_control_flags_ff[`RCI_PCN_BOR] == ($past(cause) == CAUSE_BOR ? 1'b0 : $past(power_control_flags_ff[0])));
  endproperty
  a_bor_bit: assert property (p_bor_bit) else $error("power flag bit 0 wrong");

  property p_wake_flags;
    @(posedge hclk) disable iff (!hresetn)
    (cause == CAUSE_IRQ_WAKE) |=> ((irqctl_ff[2:0] | pflag_ff[6:0]) != 7'h00);
  endproperty
  a_wake_flags: assert property (p_wake_flags) else $error("wake left no flag");

  property p_alias;
    @(posedge hclk) disable iff (!hresetn)
    (accept && !hwrite && idx == `RCI_IDX_SADDR && smode_ff == `RCI_SMODE_MASK) |=>
      (hrdata == {24'h0, $past(smask_ff)});
  endproperty
  a_alias: assert property (p_alias) else $error("mask alias not routed");

  property p_unimpl;
    @(posedge hclk) disable iff (!hresetn)
    ((power_control_flags_ff & ~`RCI_POWER_CONTROL_FLAGS_IMPL) == 8'h00) && !pflag_ff[7] &&
      (!$past(accept && !hwrite && idx == `RCI_IDX_POWER_CONTROL_FLAGS) || (hrdata[31:6] == 26'h0));
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

  property p_gie_clear;
    @(posedge hclk) disable iff (!hresetn)
    is_reset |=> !global_irq_enable ##1 (vec_ff == VEC_IDLE);
  endproperty
  a_gie_clear: assert property (p_gie_clear) else $error("enable survived reset");

  property p_priority;
    @(posedge hclk) disable iff (!hresetn)
    (por_req |-> cause == CAUSE_POR) and
      ((!por_req && bor_req) |-> cause == CAUSE_BOR) and
      ((!por_req && !bor_req && ext_evt) |-> (cause inside {CAUSE_EXT_RUN, CAUSE_EXT_SLEEP}));
  endproperty
  a_priority: assert property (p_priority) else $error("cause priority broken");
endmodule : rci_top
`default_nettype wire

/* File: tb/test_reset_cause_init_logic.sv */
// Self-checking testbench for the reset-cause initialization logic.
`timescale 1ns/1ps
`default_nettype none
module test_reset_cause_init_logic;
  import rci_pkg::*;
  localparam int PW = 13;
  localparam logic [7:0] ST = 8'h03, IC = 8'h0B, PF = 8'h0C, SM = 8'h14;
  localparam logic [7:0] PN = 8'h8E, SA = 8'h93, ES = 8'hC0, EM = 8'hC1;
  logic          hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]   haddr, hwdata, hrdata, seed, rw;
  logic [1:0]    htrans;
  logic [2:0]    hsize, wake_ctl_flags;
  logic [6:0]    wake_per_flags;
  logic          external_reset_pin_n, por_req, bor_req, wdt_timeout;
  logic          sleeping, instr_done, pc_load, global_irq_enable, irq;
  logic          rd_pend, mon_on;
  logic [PW-1:0] core_pc, pc_value, pcv, nx;
  logic [31:0]   rq[$], pq[$];
  int            error_cnt, n_compared, n_pc;

  assign hready = hreadyout;

  rci_top #(.PC_W(PW)) rci_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .external_reset_pin_n(external_reset_pin_n), .por_req(por_req),
    .bor_req(bor_req), .wdt_timeout(wdt_timeout), .sleeping(sleeping),
    .instr_done(instr_done), .core_pc(core_pc), .wake_ctl_flags(wake_ctl_flags),
    .wake_per_flags(wake_per_flags), .pc_load(pc_load), .pc_value(pc_value),
    .global_irq_enable(global_irq_enable), .irq(irq)
  );

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic edge_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      give_verdict();
    end
  endtask : edge_rdy

  // A read pushes its expected word; the watcher below compares it.
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] d);
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'b10;
    edge_rdy();
    htrans <= 2'b00;
    hwdata <= wr ? d : 32'h0;
    if (!wr) begin
      rq.push_back(d);
      rd_pend <= 1'b1;
    end
    edge_rdy();
    rd_pend <= 1'b0;
  endtask : bus

  // Bits of s: 0 power-on, 1 brown-out, 2 watchdog, 3 pin, 4 wake flags, 5 instr_done.
  task automatic fire(input logic [5:0] s, input logic [31:0] pce);
    int t;
    int k;
    t = n_pc + 1;
    k = 0;
    pq.push_back(pce);
    @(posedge hclk);
    {external_reset_pin_n, wdt_timeout, bor_req, por_req} <= {~s[3], s[2:0]};
    wake_per_flags <= s[4] ? 7'h05 : 7'h00;
    wake_ctl_flags <= s[4] ? 3'h2 : 3'h0;
    instr_done <= s[5];
    @(posedge hclk);
    {wdt_timeout, bor_req, por_req, instr_done} <= 4'h0;
    wake_per_flags <= 7'h00;
    wake_ctl_flags <= 3'h0;
    while (n_pc < t && k < 40) begin
      @(posedge hclk);
      k++;
    end
    if (n_pc < t) begin
      error_cnt++;
      give_verdict();
    end
    external_reset_pin_n <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask : fire

  always @(posedge hclk) begin
    if (rd_pend === 1'b1 && hreadyout === 1'b1) begin
      cmp(hrdata, rq.pop_front());
      cmp(hresp, 32'h0);
    end
    if (mon_on === 1'b1 && pc_load === 1'b1) begin
      n_pc++;
      cmp({19'h0, pc_value}, (pq.size() > 0) ? pq.pop_front() : 32'hFFFFFFFF);
    end
  end

  initial begin
    seed = 32'hcc8b;
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    external_reset_pin_n = 1'b1;
    {por_req, bor_req, wdt_timeout, sleeping, instr_done} = 5'h0;
    core_pc = '0;
    wake_ctl_flags = 3'h0;
    wake_per_flags = 7'h00;
    rd_pend = 1'b0;
    mon_on = 1'b0;
    error_cnt = 0;
    n_compared = 0;
    n_pc = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    mon_on <= 1'b1;
    bus(ST, 1'b0, 32'h18);
    bus(PN, 1'b0, 32'h10);
    bus(ES, 1'b0, 32'h01);
    bus(ES, 1'b0, 32'h00);
    bus(PN, 1'b1, 32'hFF);
    bus(PN, 1'b0, 32'h33);
    bus(8'h50, 1'b1, 32'hFF);
    bus(8'h50, 1'b0, 32'h00);
    bus(EM, 1'b1, 32'h04);
    $display("test power_on_values done");
    bus(ST, 1'b1, 32'hE7);
    bus(IC, 1'b1, 32'h81);
    @(posedge hclk);
    cmp(global_irq_enable, 32'h1);
    fire(6'h08, 32'h0);
    cmp(global_irq_enable, 32'h0);
    cmp(irq, 32'h1);
    bus(ST, 1'b0, 32'h1F);
    bus(PN, 1'b0, 32'h13);
    bus(IC, 1'b0, 32'h01);
    bus(ES, 1'b0, 32'h04);
    repeat (2) @(posedge hclk);
    cmp(irq, 32'h0);
    $display("test pin_reset_run done");
    sleeping <= 1'b1;
    bus(ST, 1'b1, 32'hE5);
    fire(6'h08, 32'h0);
    cmp(irq, 32'h0);
    sleeping <= 1'b0;
    bus(ST, 1'b0, 32'h15);
    bus(PN, 1'b0, 32'h13);
    bus(ES, 1'b0, 32'h08);
    $display("test pin_reset_sleep done");
    bus(PN, 1'b1, 32'h33);
    fire(6'h04, 32'h0);
    bus(PN, 1'b0, 32'h13);
    bus(ST, 1'b0, 32'h05);
    bus(ES, 1'b0, 32'h10);
    fire(6'h02, 32'h0);
    bus(PN, 1'b0, 32'h12);
    bus(ST, 1'b0, 32'h1D);
    bus(ES, 1'b0, 32'h02);
    $display("test watchdog_brownout done");
    fire(6'h07, 32'h0);
    bus(ST, 1'b0, 32'h18);
    bus(PN, 1'b0, 32'h10);
    bus(ES, 1'b0, 32'h01);
    fire(6'h06, 32'h0);
    bus(ES, 1'b0, 32'h02);
    $display("test priority done");
    bus(ST, 1'b1, 32'hE0);
    bus(IC, 1'b1, 32'h80);
    pcv = PW'($random(seed));
    nx = pcv + 13'h1;
    core_pc <= pcv;
    sleeping <= 1'b1;
    fire(6'h10, {19'h0, nx});
    sleeping <= 1'b0;
    bus(ST, 1'b0, 32'hF0);
    bus(PN, 1'b0, 32'h10);
    bus(PF, 1'b0, 32'h05);
    bus(IC, 1'b0, 32'h82);
    cmp(global_irq_enable, 32'h1);
    fire(6'h20, 32'h4);
    cmp(global_irq_enable, 32'h0);
    bus(IC, 1'b0, 32'h02);
    pcv = PW'($random(seed));
    nx = pcv + 13'h1;
    core_pc <= pcv;
    sleeping <= 1'b1;
    fire(6'h04, {19'h0, nx});
    sleeping <= 1'b0;
    bus(ST, 1'b0, 32'hE0);
    $display("test wake_up done");
    rw = $random(seed);
    bus(SA, 1'b1, 32'h5A);
    bus(SM, 1'b1, 32'h09);
    bus(SA, 1'b0, 32'hFF);
    bus(SA, 1'b1, rw);
    bus(SA, 1'b0, {24'h0, rw[7:0]});
    bus(SM, 1'b1, 32'h00);
    bus(SA, 1'b0, 32'h5A);
    $display("test serial_mask_alias done");
    give_verdict();
  end
endmodule : test_reset_cause_init_logic
`default_nettype wire
